// ==== hw/tdsl_steer.sv ====
// guard-time steering and digit code latch
// Notes on behaviour
// - short tone bursts leave latched code unchanged
// - valid tone decodes and latches code
// - code held until next valid tone
// - low enable floats digit outputs
// - latching continues while outputs disabled
// - short dropout keeps code and valid flag
// - early steer on valid frequencies immediately
// - delayed steer after present/absent guard times
// - steer pin senses input and drives network
// - code is four parallel bits
// - tone shorter than recognition time rejected
// - power-up latency ends at early steer
// - presence detected 5 to 14 ms
// - outputs update within 11 us of steer
`timescale 1ns/1ps
`include "tdsl_consts.svh"
module tdsl_steer #(
   parameter int DETECT_CYC = `TDSL_DETECT_CYC,
   parameter int ABSENT_CYC = `TDSL_ABSENT_CYC
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             tone_valid_in,
   input  wire tdsl_pkg::tdsl_code_t tone_code_in,
   input  wire logic             power_down_in,
   input  wire logic             code_output_enable,
   input  wire logic             steer_guard_pin_in,
   output logic                  steer_guard_pin_out,
   output logic                  steer_guard_pin_oe_n,
   output logic                  early_steer_out,
   output logic                  delayed_steer_out,
   output tdsl_pkg::tdsl_code_t  digit_code_out,
   output logic                  digit_code_oe_n
);
   import tdsl_pkg::*;

   localparam int CW = 24;
   logic [5:0]  sync_q;
   logic        tone_s;
   tdsl_code_t  code_s;
   logic        pdn_s;
   logic        toe_s;
   logic        pin_s;
   logic [CW-1:0] guard_cnt;
   tdsl_state_t state;
   tdsl_state_t next_state;
   tdsl_code_t  code_latch;
   logic        latch_now;

   // every pin input crosses two flops before use
   tdsl_sync #(.W(6)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .d        ({tone_valid_in, tone_code_in, power_down_in}),
      .q        (sync_q)
   );
   assign tone_s = sync_q[5];
   assign code_s = sync_q[4:1];
   assign pdn_s  = sync_q[0];

   // output enable and steer pin sense also cross into this domain
   tdsl_sync #(.W(2)) u_sync2 (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .d        ({code_output_enable, steer_guard_pin_in}),
      .q        ({toe_s, pin_s})
   );

   // early steer follows detection directly, gated by power down
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         early_steer_out <= 1'b0;
      end else begin
         early_steer_out <= tone_s && !pdn_s;
      end
   end

   // guard state machine: any change of tone condition restarts the count
   always_comb begin
      next_state = state;
      unique case (state)
         TDSL_IDLE:    if (tone_s) next_state = TDSL_DETECT;
         TDSL_DETECT: begin
            if (!tone_s) begin
               next_state = TDSL_IDLE;
            end else if (guard_cnt >= CW'(DETECT_CYC - 1) && pin_s) begin
               next_state = TDSL_STEER;
            end
         end
         TDSL_STEER:   if (!tone_s) next_state = TDSL_RELEASE;
         TDSL_RELEASE: begin
            if (tone_s) begin
               next_state = TDSL_STEER;
            end else if (guard_cnt >= CW'(ABSENT_CYC - 1) && !pin_s) begin
               next_state = TDSL_IDLE;
            end
         end
      endcase
      if (pdn_s) next_state = TDSL_IDLE;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= TDSL_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // guard counter cleared at every state change
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         guard_cnt <= '0;
      end else if (next_state != state) begin
         guard_cnt <= '0;
      end else if (guard_cnt != {CW{1'b1}}) begin
         guard_cnt <= guard_cnt + 1'b1;
      end
   end

   assign latch_now = (state == TDSL_DETECT) && (next_state == TDSL_STEER);

   // code latched one cycle after qualification, independent of enable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         code_latch <= `TDSL_CODE_RESET;
      end else if (latch_now) begin
         code_latch <= code_s;
      end
   end // otherwise held

   // delayed steer mirrors the qualified state, kept through dropouts
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         delayed_steer_out <= 1'b0;
      end else begin
         delayed_steer_out <= (next_state == TDSL_STEER) ||
                              (next_state == TDSL_RELEASE);
      end
   end

   // pin driven as guard output; its sensed level gates the guard transitions,
   // so a network that holds the pin back also holds back steering
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         steer_guard_pin_out <= 1'b0;
      end else begin
         steer_guard_pin_out <= tone_s && !pdn_s;
      end
   end
   assign steer_guard_pin_oe_n = 1'b0;

   assign digit_code_out  = code_latch;
   assign digit_code_oe_n = !toe_s;

   a_reject_short: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == TDSL_DETECT && !tone_s) |=> $stable(code_latch))
      else $error("short burst changed code");
   a_latch_value: assert property (@(posedge core_clk) disable iff (!reset_n)
      latch_now |=> code_latch == $past(code_s))
      else $error("code not latched");
   a_hold_code: assert property (@(posedge core_clk) disable iff (!reset_n)
      !latch_now |=> $stable(code_latch))
      else $error("code changed without latch");

   // checks on output enable, early steer, power down, the guard machine and the latched code
   a_enable_float: assert property (@(posedge core_clk) disable iff (!reset_n)
      $changed(digit_code_oe_n) |-> digit_code_oe_n == !$past(code_output_enable, 2))
      else $error("enable mismatch");
   a_dropout_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == TDSL_RELEASE && tone_s && !pdn_s) |=> delayed_steer_out)
      else $error("dropout ended digit");
   a_early_steer: assert property (@(posedge core_clk) disable iff (!reset_n)
      (tone_s && !pdn_s) |=> early_steer_out)
      else $error("early steer late");
   a_steer_guard: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(delayed_steer_out) |-> $past(state) == TDSL_DETECT)
      else $error("delayed steer without guard");
   a_power_down: assert property (@(posedge core_clk) disable iff (!reset_n)
      pdn_s |=> !early_steer_out && !delayed_steer_out)
      else $error("steer during power down");
   a_detect_span: assert property (@(posedge core_clk) disable iff (!reset_n)
      latch_now |-> guard_cnt >= CW'(DETECT_CYC - 1) && pin_s)
      else $error("digit accepted before present guard");
   a_release_guard: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == TDSL_RELEASE && next_state == TDSL_IDLE && !pdn_s) |-> !pin_s && guard_cnt >= CW'(ABSENT_CYC - 1))
      else $error("digit ended before absent guard");
   a_code_update: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(delayed_steer_out) |-> code_latch == $past(code_s))
      else $error("code not ready with delayed steer");
   c_valid_digit: cover property (@(posedge core_clk) disable iff (!reset_n) latch_now);
   c_dropout: cover property (@(posedge core_clk) disable iff (!reset_n)
      state == TDSL_RELEASE ##1 state == TDSL_STEER);
   c_reject: cover property (@(posedge core_clk) disable iff (!reset_n)
      state == TDSL_DETECT ##1 state == TDSL_IDLE);
   c_hidden_latch: cover property (@(posedge core_clk) disable iff (!reset_n)
      latch_now && !toe_s);
   c_power_down: cover property (@(posedge core_clk) disable iff (!reset_n)
      pdn_s && tone_s);
endmodule : tdsl_steer

// ==== hw/tdsl_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tdsl_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   // first stage read only by the second stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : tdsl_sync

// ==== pkg/tdsl_consts.svh ====
// timing and field constants for the tone digit steering latch
`ifndef TDSL_CONSTS_SVH
`define TDSL_CONSTS_SVH
`define TDSL_CLK_HZ          25000000
`define TDSL_CODE_W          4
`define TDSL_DETECT_MIN_MS   5
`define TDSL_DETECT_MAX_MS   14
`define TDSL_DETECT_CYC      ((`TDSL_CLK_HZ / 1000) * `TDSL_DETECT_MIN_MS)
`define TDSL_UPDATE_MAX_US   11
`define TDSL_UPDATE_CYC      ((`TDSL_CLK_HZ / 1000000) * `TDSL_UPDATE_MAX_US)
`define TDSL_ABSENT_CYC      250
`define TDSL_CODE_RESET      4'h0
`endif

// ==== pkg/tdsl_pkg.sv ====
// types for the tone digit steering latch
package tdsl_pkg;
   typedef logic [3:0] tdsl_code_t;
   typedef enum logic [1:0] {
      TDSL_IDLE    = 2'b00,
      TDSL_DETECT  = 2'b01,
      TDSL_STEER   = 2'b11,
      TDSL_RELEASE = 2'b10
   } tdsl_state_t;
endpackage : tdsl_pkg

// ==== test/tdsl_host.sv ====
// host model that gates and reads the latched digit code
`timescale 1ns/1ps
module tdsl_host (
   input  wire logic                 core_clk,
   input  wire logic                 delayed_steer_out,
   input  wire tdsl_pkg::tdsl_code_t digit_code_out,
   input  wire logic                 digit_code_oe_n,
   output tdsl_pkg::tdsl_code_t      bus_level,
   output tdsl_pkg::tdsl_code_t      seen_code
);
   import tdsl_pkg::*;
   tdsl_code_t last_driven = 4'h0;
   logic       steer_seen  = 1'b0;
   // a floating bus shows the inverse of its last level, so a stale code never passes
   assign bus_level = digit_code_oe_n ? ~last_driven : digit_code_out;
   // remember the driven level and read the code when a new digit is flagged
   always_ff @(posedge core_clk) begin
      if (!digit_code_oe_n) begin
         last_driven <= digit_code_out;
      end
      if (delayed_steer_out && !steer_seen) begin
         seen_code <= bus_level;
      end
      steer_seen <= delayed_steer_out;
   end
endmodule : tdsl_host

// ==== test/test_tdsl_steer.sv ====
// self-checking bench for the tone digit steering latch
`timescale 1ns/1ps
module test_tdsl_steer;
   import tdsl_pkg::*;
   logic       core_clk = 1'b0, reset_n = 1'b0, tone_valid_in = 1'b0;
   logic       power_down_in = 1'b0, code_output_enable = 1'b1;
   tdsl_code_t tone_code_in = 4'h0;
   logic       guard_out, guard_oe_n, early_steer_out, delayed_steer_out, digit_code_oe_n;
   tdsl_code_t digit_code_out, bus_level, seen_code;
   int         errors = 0, checks_done = 0;
   initial forever #20 core_clk = ~core_clk;
   // short guard counts keep the run brief; the user picks them anyway
   tdsl_steer #(.DETECT_CYC(20), .ABSENT_CYC(8)) dut (
      .core_clk(core_clk), .reset_n(reset_n), .tone_valid_in(tone_valid_in),
      .tone_code_in(tone_code_in), .power_down_in(power_down_in),
      .code_output_enable(code_output_enable),
      .steer_guard_pin_in(guard_oe_n ? 1'b1 : guard_out),
      .steer_guard_pin_out(guard_out), .steer_guard_pin_oe_n(guard_oe_n),
      .early_steer_out(early_steer_out), .delayed_steer_out(delayed_steer_out),
      .digit_code_out(digit_code_out), .digit_code_oe_n(digit_code_oe_n));
   tdsl_host host (.core_clk(core_clk), .delayed_steer_out(delayed_steer_out),
      .digit_code_out(digit_code_out), .digit_code_oe_n(digit_code_oe_n),
      .bus_level(bus_level), .seen_code(seen_code));
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp
   task automatic tone(input logic on, input tdsl_code_t c);
      tone_code_in = c;
      tone_valid_in = on;
   endtask : tone
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   // burst, valid digit with dropout, disabled outputs, then power down
   initial begin
      step(10);
      cmp(digit_code_oe_n, 4'h1);
      cmp(digit_code_out, 4'h0);
      reset_n = 1'b1;
      step(2);
      tone(1'b1, 4'h5);
      step(4);
      cmp(early_steer_out, 4'h1);
      cmp(guard_out, 4'h1);
      cmp(guard_oe_n, 4'h0);
      step(6);
      tone(1'b0, 4'h5);
      step(30);
      cmp(delayed_steer_out, 4'h0);
      cmp(digit_code_out, 4'h0);
      tone(1'b1, 4'hA);
      step(40);
      cmp(delayed_steer_out, 4'h1);
      cmp(digit_code_out, 4'hA);
      cmp(seen_code, 4'hA);
      tone(1'b0, 4'hA);
      step(3);
      tone(1'b1, 4'hA);
      step(10);
      cmp(delayed_steer_out, 4'h1);
      tone(1'b0, 4'h0);
      step(20);
      cmp(delayed_steer_out, 4'h0);
      cmp(digit_code_out, 4'hA);
      code_output_enable = 1'b0;
      step(4);
      cmp(digit_code_oe_n, 4'h1);
      tone(1'b1, 4'h3);
      step(40);
      cmp(digit_code_out, 4'h3);
      cmp(seen_code, 4'h5);
      tone(1'b0, 4'h3);
      step(20);
      code_output_enable = 1'b1;
      step(4);
      cmp(bus_level, 4'h3);
      power_down_in = 1'b1;
      tone(1'b1, 4'h9);
      step(10);
      cmp(early_steer_out, 4'h0);
      cmp(delayed_steer_out, 4'h0);
      cmp(guard_out, 4'h0);
      power_down_in = 1'b0;
      step(4);
      cmp(early_steer_out, 4'h1);
      tone(1'b0, 4'h9);
      step(20);
      conclude();
   end
endmodule : test_tdsl_steer
